// file: include/atx_consts.svh
// Constants for the accumulator transfer execution block
`ifndef ATX_CONSTS_SVH
`define ATX_CONSTS_SVH

// ==========================================
// Register byte offsets
`define ATX_OFF_CMD 8'h00
`define ATX_OFF_CORE 8'h04
`define ATX_OFF_EREG 8'h08
`define ATX_OFF_CMP 8'h0c
`define ATX_OFF_PC 8'h10
`define ATX_OFF_DPTR 8'h14

// ==========================================
// Command register fields
`define ATX_CMD_OP_LSB 0
`define ATX_CMD_J_LSB 4
`define ATX_CMD_PAGE_LSB 8

// ==========================================
// Core register fields
`define ATX_CORE_A_LSB 0
`define ATX_CORE_B_LSB 4
`define ATX_CORE_D_LSB 8
`define ATX_CORE_X_LSB 12
`define ATX_CORE_SP_LSB 16

// ==========================================
// Reset values
`define ATX_SP_RST 3'h7
`define ATX_NIB_RST 4'h0
`define ATX_BYTE_RST 8'h00

// ==========================================
// Timing counts, in instruction cycles
`define ATX_LOOKUP_CYCLES 2'h3

`endif

// file: include/atx_pkg.sv
// Types and helper functions for the accumulator transfer execution block
`include "atx_consts.svh"
package atx_pkg;

    // Instruction selector written into the command register
    typedef enum logic [3:0] {
        ATX_OP_TIMER4 = 4'b0000,
        ATX_OP_ADC = 4'b0001,
        ATX_OP_EREG = 4'b0010,
        ATX_OP_ROMTAB = 4'b0011,
        ATX_OP_PRESC = 4'b0100,
        ATX_OP_SHIFT = 4'b0101,
        ATX_OP_DREG = 4'b0110,
        ATX_OP_WRCMP = 4'b0111,
        ATX_OP_INT1 = 4'b1000,
        ATX_OP_INT2 = 4'b1001,
        ATX_OP_SCTRL = 4'b1010,
        ATX_OP_WAKE0 = 4'b1011,
        ATX_OP_WAKE1 = 4'b1100,
        ATX_OP_WAKE2 = 4'b1101,
        ATX_OP_ADCLO = 4'b1110,
        ATX_OP_RAMX = 4'b1111
    } atx_op_e;

    // Table lookup sequence states
    typedef enum logic [1:0] {
        ATX_ST_IDLE = 2'b00,
        ATX_ST_FETCH = 2'b01,
        ATX_ST_POP = 2'b10
    } atx_state_e;

    // True when a byte address names a mapped register
    function automatic logic atx_reg_hit(input logic [7:0] addr);
        atx_reg_hit = (addr == `ATX_OFF_CMD) || (addr == `ATX_OFF_CORE) ||
            (addr == `ATX_OFF_EREG) || (addr == `ATX_OFF_CMP) ||
            (addr == `ATX_OFF_PC) || (addr == `ATX_OFF_DPTR);
    endfunction

    // Merge a bus write into an old word under its byte enables
    function automatic logic [31:0] atx_merge(input logic [31:0] old_w,
        input logic [31:0] new_w, input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        atx_merge = res;
    endfunction

endpackage

// file: src/atx_axil_slave.sv
// AXI4-Lite slave front end for the accumulator transfer block
`timescale 1ns/1ps
`include "atx_consts.svh"
module atx_axil_slave
    import atx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic rready,
    output logic rvalid,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [31:0] rd_word,
    input wire logic rd_hit,
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb
);

    // All handshake state in one word
    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wr;
        logic bv;
        logic berr;
        logic rv;
        logic rerr;
        logic [31:0] rdata;
    } atx_axs_s;

    localparam atx_axs_s AXS_RST = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
        default: '0};

    atx_axs_s s_r; // Registered state
    atx_axs_s s_nxt; // Next state

    // ==========================================
    // Handshake next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.wr = 1'b0;
        // Address and data may arrive in either order
        if (s_r.aw_rdy && awvalid) begin
            s_nxt.aw_rdy = 1'b0;
            s_nxt.aw_got = 1'b1;
            s_nxt.waddr = awaddr;
        end
        if (s_r.w_rdy && wvalid) begin
            s_nxt.w_rdy = 1'b0;
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = wdata;
            s_nxt.wstrb = wstrb;
        end
        // Both halves held: commit and answer
        if (s_r.aw_got && s_r.w_got && !s_r.bv) begin
            s_nxt.wr = 1'b1;
            s_nxt.bv = 1'b1;
            s_nxt.berr = !atx_reg_hit(s_r.waddr);
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
        end
        // Reopen only after the response is taken
        if (s_r.bv && bready) begin
            s_nxt.bv = 1'b0;
            s_nxt.aw_rdy = 1'b1;
            s_nxt.w_rdy = 1'b1;
        end
        // Reads answer one cycle after the address is taken
        if (s_r.ar_rdy && arvalid) begin
            s_nxt.ar_rdy = 1'b0;
            s_nxt.rv = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rerr = !rd_hit;
        end
        if (s_r.rv && rready) begin
            s_nxt.rv = 1'b0;
            s_nxt.ar_rdy = 1'b1;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= AXS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.aw_rdy;
    assign wready = s_r.w_rdy;
    assign arready = s_r.ar_rdy;
    assign bvalid = s_r.bv;
    assign bresp = s_r.berr ? 2'h2 : 2'h0;
    assign rvalid = s_r.rv;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rerr ? 2'h2 : 2'h0;
    assign wr_pulse = s_r.wr;
    assign wr_addr = s_r.waddr;
    assign wr_data = s_r.wdata;
    assign wr_strb = s_r.wstrb;

endmodule

// file: src/atx_exec.sv
// Execution unit for the accumulator transfer instruction group
`timescale 1ns/1ps
`include "atx_consts.svh"
// Summary of operation
// - Timer 4 count high to B, low to A
// - Conversion mode: result 9..6 to B, 5..2 to A
// - Comparator mode: comparator 7..4 to B, 3..0 A
// - E register high to B, low to A
// - Word splits into D, B, A; then pop PC
// - Prescaler high to B, low to A
// - Serial shift high to B, low to A
// - D to A bits 2..0, A3 cleared
// - Comparator write from B,A only in comparator mode
// - Interrupt control one or two to A
// - Serial control register to A
// - Chosen wakeup control register to A
// - Result bits 1,0 to A3,A2; A1,A0 cleared
// - RAM nibble to A, then X ^= j
module atx_exec
    import atx_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic [7:0] TMR4_COUNT,
    input wire logic [9:0] ADC_RESULT,
    input wire logic [3:0] ADC_CONTROL_ONE,
    input wire logic [7:0] TIMER_PRESCALER,
    input wire logic [7:0] SERIAL_SHIFT,
    input wire logic [3:0] INT_CTRL_ONE,
    input wire logic [3:0] INT_CTRL_TWO,
    input wire logic [3:0] SERIAL_CTRL,
    input wire logic [3:0] WAKEUP_CTRL_ZERO,
    input wire logic [3:0] WAKEUP_CTRL_ONE,
    input wire logic [3:0] WAKEUP_CTRL_TWO,
    output logic [8:0] RAM_ADDR,
    input wire logic [3:0] RAM_RDATA,
    output logic [12:0] ROM_ADDR,
    input wire logic [9:0] ROM_RDATA,
    output logic [7:0] CMP_VALUE,
    output logic BUSY
);

    // ==========================================
    // State word
    typedef struct packed {
        atx_state_e st; // Lookup sequence state
        logic [3:0] acc; // Accumulator
        logic [3:0] breg; // B register
        logic [2:0] page_low_reg; // D register
        logic [1:0] xreg; // X register
        logic [7:0] ereg; // E register
        logic [7:0] cmp; // Comparator register
        logic [2:0] stack_ptr; // Return stack pointer
        logic [7:0][12:0] return_stack; // Return stack, eight levels
        logic [5:0] pc_page_part; // Program counter page
        logic [6:0] pc_low_part; // Program counter low address
        logic [8:0] data_pointer; // RAM address
        logic [3:0] last_op; // Last accepted instruction
        logic dropped; // Sticky: command refused while busy
        logic [12:0] rom_addr; // Address shown to the ROM
    } atx_core_s;

    atx_core_s c_r; // Registered state
    atx_core_s c_nxt; // Next state

    logic wr_pulse; // One-cycle register write strobe
    logic [7:0] wr_addr; // Write byte address
    logic [31:0] wr_data; // Write data
    logic [3:0] wr_strb; // Write byte enables
    logic [31:0] rd_word; // Read mux output

    // ==========================================
    // Bus front end
    atx_axil_slave u_slave (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .awaddr(S_AXI_AWADDR),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .bresp(S_AXI_BRESP),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rready(S_AXI_RREADY),
        .rvalid(S_AXI_RVALID),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rd_word(rd_word),
        .rd_hit(atx_reg_hit(S_AXI_ARADDR)),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb)
    );

    // Protection bits carry no meaning here
    logic prot_unused;
    assign prot_unused = ^{S_AXI_AWPROT, S_AXI_ARPROT};

    // Packs the core registers into their bus word
    function automatic logic [31:0] core_word(input atx_core_s c);
        logic [31:0] w;
        w = 32'h0;
        w[`ATX_CORE_A_LSB +: 4] = c.acc;
        w[`ATX_CORE_B_LSB +: 4] = c.breg;
        w[`ATX_CORE_D_LSB +: 3] = c.page_low_reg;
        w[`ATX_CORE_X_LSB +: 2] = c.xreg;
        w[`ATX_CORE_SP_LSB +: 3] = c.stack_ptr;
        core_word = w;
    endfunction

    // ==========================================
    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0;
        case (S_AXI_ARADDR)
            `ATX_OFF_CMD: begin
                rd_word = {26'h0, c_r.dropped, c_r.last_op, c_r.st != ATX_ST_IDLE};
            end
            `ATX_OFF_CORE: begin
                rd_word = core_word(c_r);
            end
            `ATX_OFF_EREG: begin
                rd_word = {24'h0, c_r.ereg};
            end
            `ATX_OFF_CMP: begin
                rd_word = {24'h0, c_r.cmp};
            end
            `ATX_OFF_PC: begin
                rd_word = {19'h0, c_r.pc_page_part, c_r.pc_low_part};
            end
            `ATX_OFF_DPTR: begin
                rd_word = {23'h0, c_r.data_pointer};
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    // ==========================================
    // Software writes, then instruction execution
    always_comb begin
        logic [31:0] mw; // Merged write word
        logic [3:0] op; // Decoded opcode field
        logic [1:0] jimm; // RAM instruction immediate
        logic [5:0] page; // Lookup page
        logic [2:0] sp_up; // Stack pointer after push
        logic start; // Command write accepted
        mw = 32'h0;
        op = 4'h0;
        jimm = 2'h0;
        page = 6'h0;
        sp_up = 3'h0;
        start = 1'b0;
        c_nxt = c_r;

        // Register writes from the bus
        if (wr_pulse) begin
            case (wr_addr)
                `ATX_OFF_CMD: begin
                    mw = atx_merge(32'h0, wr_data, wr_strb);
                    op = mw[`ATX_CMD_OP_LSB +: 4];
                    jimm = mw[`ATX_CMD_J_LSB +: 2];
                    page = mw[`ATX_CMD_PAGE_LSB +: 6];
                    // A lookup in flight owns the core; late commands drop
                    if (c_r.st == ATX_ST_IDLE) begin
                        start = 1'b1;
                        c_nxt.last_op = op;
                    end else begin
                        c_nxt.dropped = 1'b1;
                    end
                    // Writing bit 5 of byte 0 while idle clears the drop flag
                    if (wr_strb[0] && wr_data[5] && c_r.st == ATX_ST_IDLE) begin
                        c_nxt.dropped = 1'b0;
                    end
                end
                `ATX_OFF_CORE: begin
                    mw = atx_merge(core_word(c_r), wr_data, wr_strb);
                    c_nxt.acc = mw[`ATX_CORE_A_LSB +: 4];
                    c_nxt.breg = mw[`ATX_CORE_B_LSB +: 4];
                    c_nxt.page_low_reg = mw[`ATX_CORE_D_LSB +: 3];
                    c_nxt.xreg = mw[`ATX_CORE_X_LSB +: 2];
                    c_nxt.stack_ptr = mw[`ATX_CORE_SP_LSB +: 3];
                end
                `ATX_OFF_EREG: begin
                    mw = atx_merge({24'h0, c_r.ereg}, wr_data, wr_strb);
                    c_nxt.ereg = mw[7:0];
                end
                `ATX_OFF_PC: begin
                    mw = atx_merge({19'h0, c_r.pc_page_part, c_r.pc_low_part},
                        wr_data, wr_strb);
                    c_nxt.pc_page_part = mw[12:7];
                    c_nxt.pc_low_part = mw[6:0];
                end
                `ATX_OFF_DPTR: begin
                    mw = atx_merge({23'h0, c_r.data_pointer}, wr_data, wr_strb);
                    c_nxt.data_pointer = mw[8:0];
                end
                default: begin
                    // Comparator is written only by instruction
                    c_nxt.dropped = c_r.dropped;
                end
            endcase
        end

        // Single-cycle transfers finish on the edge after the strobe
        if (start) begin
            case (op)
                ATX_OP_TIMER4: begin
                    c_nxt.breg = TMR4_COUNT[7:4];
                    c_nxt.acc = TMR4_COUNT[3:0];
                end
                ATX_OP_ADC: begin
                    if (!ADC_CONTROL_ONE[3]) begin
                        c_nxt.breg = ADC_RESULT[9:6];
                        c_nxt.acc = ADC_RESULT[5:2];
                    end else begin
                        c_nxt.breg = c_r.cmp[7:4];
                        c_nxt.acc = c_r.cmp[3:0];
                    end
                end
                ATX_OP_EREG: begin
                    c_nxt.breg = c_r.ereg[7:4];
                    c_nxt.acc = c_r.ereg[3:0];
                end
                ATX_OP_ROMTAB: begin
                    // Push the return address above the current top
                    sp_up = c_r.stack_ptr + 3'h1;
                    c_nxt.stack_ptr = sp_up;
                    c_nxt.return_stack[sp_up] = {c_r.pc_page_part, c_r.pc_low_part};
                    // Page sits in the high part; D and A form the low part
                    c_nxt.pc_page_part = page;
                    c_nxt.pc_low_part = {c_r.page_low_reg, c_r.acc};
                    c_nxt.rom_addr = {page, c_r.page_low_reg, c_r.acc};
                    c_nxt.st = ATX_ST_FETCH;
                end
                ATX_OP_PRESC: begin
                    c_nxt.breg = TIMER_PRESCALER[7:4];
                    c_nxt.acc = TIMER_PRESCALER[3:0];
                end
                ATX_OP_SHIFT: begin
                    c_nxt.breg = SERIAL_SHIFT[7:4];
                    c_nxt.acc = SERIAL_SHIFT[3:0];
                end
                ATX_OP_DREG: begin
                    c_nxt.acc = {1'b0, c_r.page_low_reg};
                end
                ATX_OP_WRCMP: begin
                    // In conversion mode this behaves as a no-op
                    if (ADC_CONTROL_ONE[3]) begin
                        c_nxt.cmp = {c_r.breg, c_r.acc};
                    end
                end
                ATX_OP_INT1: begin
                    c_nxt.acc = INT_CTRL_ONE;
                end
                ATX_OP_INT2: begin
                    c_nxt.acc = INT_CTRL_TWO;
                end
                ATX_OP_SCTRL: begin
                    c_nxt.acc = SERIAL_CTRL;
                end
                ATX_OP_WAKE0: begin
                    c_nxt.acc = WAKEUP_CTRL_ZERO;
                end
                ATX_OP_WAKE1: begin
                    c_nxt.acc = WAKEUP_CTRL_ONE;
                end
                ATX_OP_WAKE2: begin
                    c_nxt.acc = WAKEUP_CTRL_TWO;
                end
                ATX_OP_ADCLO: begin
                    c_nxt.acc = {ADC_RESULT[1:0], 2'b00};
                end
                ATX_OP_RAMX: begin
                    // RAM is read at the pointer already shown on RAM_ADDR
                    c_nxt.acc = RAM_RDATA;
                    c_nxt.xreg = c_r.xreg ^ jimm;
                end
                default: begin
                    c_nxt.acc = c_r.acc;
                end
            endcase
        end

        // Remaining two cycles of the table lookup
        case (c_r.st)
            ATX_ST_IDLE: begin
                c_nxt.rom_addr = start ? c_nxt.rom_addr : c_r.rom_addr;
            end
            ATX_ST_FETCH: begin
                // ROM answers combinationally to the registered address
                c_nxt.page_low_reg = {1'b0, ROM_RDATA[9:8]};
                c_nxt.breg = ROM_RDATA[7:4];
                c_nxt.acc = ROM_RDATA[3:0];
                c_nxt.st = ATX_ST_POP;
            end
            ATX_ST_POP: begin
                // Restore and release the level borrowed by the push
                {c_nxt.pc_page_part, c_nxt.pc_low_part} =
                    c_r.return_stack[c_r.stack_ptr];
                c_nxt.stack_ptr = c_r.stack_ptr - 3'h1;
                c_nxt.st = ATX_ST_IDLE;
            end
            default: begin
                c_nxt.st = ATX_ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            c_r <= '{st: ATX_ST_IDLE, stack_ptr: `ATX_SP_RST, default: '0};
        end else begin
            c_r <= c_nxt;
        end
    end

    // Outputs straight from the state flops
    assign RAM_ADDR = c_r.data_pointer;
    assign ROM_ADDR = c_r.rom_addr;
    assign CMP_VALUE = c_r.cmp;
    assign BUSY = (c_r.st != ATX_ST_IDLE);

endmodule

// file: bench/atx_exec_checker.sv
// Bus and lookup timing checker for the transfer execution block
`timescale 1ns/1ps
module atx_exec_checker (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic BUSY
);
    // ==========================================
    // Single clock domain, so one default suffices
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    // ==========================================
    // Lookup occupancy
    property p_busy2;
        $rose(BUSY) |=> BUSY ##1 !BUSY;
    endproperty
    a_busy2: assert property (p_busy2) else $error("lookup busy not two cycles");
    // Lookup starts only right after a write answer
    property p_busy_src;
        $rose(BUSY) |-> $past(S_AXI_BVALID);
    endproperty
    a_busy_src: assert property (p_busy_src) else $error("busy without a command");

    // ==========================================
    // Register bus answers
    property p_bans;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID;
    endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_rans;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bhold;
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer not retired");
    property p_rhold;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY;
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not retired");
    property p_bwait;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_bwait: assert property (p_bwait) else $error("write taken while answering");
    property p_err;
        S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error read carries data");
endmodule

bind atx_exec atx_exec_checker i_chk (.REF_CLK, .RST_B, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .BUSY);

// file: bench/tb.sv
// Self-checking testbench for the transfer execution block
`timescale 1ns/1ps
module tb;
    // ==========================================
    // Stimulus and observed signals
    logic clk = 1'b0, rst_b = 1'b0;
    logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdt;
    logic awr, wrr, bv, arr, rv, busy;
    logic [1:0] brs, rrs, lresp;
    logic [7:0] t4 = 8'h3c, timer_prescaler = 8'h96, ssr = 8'he1, cmp;
    logic [9:0] adr = 10'h2b7;
    logic [3:0] q1 = 4'h7, i1 = 4'h9, i2 = 4'h6, sc = 4'hc, k0 = 4'h3, k1 = 4'ha, k2 = 4'h5;
    logic [8:0] ram_a;
    logic [12:0] rom_a;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    // Memories answer combinationally from the address
    wire logic [3:0] ram_d = ram_a[3:0] ^ 4'h6;
    wire logic [9:0] rom_d = rom_a[9:0] ^ 10'h1c5;

    atx_exec i_dut (.REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
        .S_AXI_BRESP(brs), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
        .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .S_AXI_RDATA(rdt),
        .S_AXI_RRESP(rrs), .TMR4_COUNT(t4), .ADC_RESULT(adr), .ADC_CONTROL_ONE(q1),
        .TIMER_PRESCALER(timer_prescaler), .SERIAL_SHIFT(ssr), .INT_CTRL_ONE(i1), .INT_CTRL_TWO(i2),
        .SERIAL_CTRL(sc), .WAKEUP_CTRL_ZERO(k0), .WAKEUP_CTRL_ONE(k1), .WAKEUP_CTRL_TWO(k2),
        .RAM_ADDR(ram_a), .RAM_RDATA(ram_d), .ROM_ADDR(rom_a), .ROM_RDATA(rom_d),
        .CMP_VALUE(cmp), .BUSY(busy));

    // ==========================================
    // Clock, hang guard, verdict
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // ==========================================
    // Bus tasks: sample at falling edge, act after rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic da, dw, db;
        {da, dw, db} = 3'b000;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        brd <= 1'b1;
        while (!db) begin
            @(negedge clk);
            db = bv && brd;
            lresp = brs;
            da = da || (awv && awr);
            dw = dw || (wv && wrr);
            @(posedge clk);
            if (da) awv <= 1'b0;
            if (dw) wv <= 1'b0;
            // Ready stays up until the answer is seen
            if (db) brd <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic da, db;
        {da, db} = 2'b00;
        @(posedge clk);
        ara <= a; arv <= 1'b1;
        rrd <= 1'b1;
        while (!db) begin
            @(negedge clk);
            db = rv && rrd;
            da = arv && arr;
            d = rdt;
            lresp = rrs;
            @(posedge clk);
            if (da) arv <= 1'b0;
            if (db) rrd <= 1'b0;
        end
    endtask
    // Core word keeps the stack pointer at its idle value
    task automatic core(input logic [3:0] a, b, input logic [2:0] d, input logic [1:0] x);
        wr(8'h04, {13'h0, 3'h7, 2'b00, x, 1'b0, d, b, a});
    endtask
    // Execute one op; four cycles cover even the lookup
    task automatic xr(input string n, input logic [3:0] op, input logic [1:0] j,
        input logic [5:0] pg, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] v;
        wr(8'h00, {18'h0, pg, 2'b00, j, op});
        repeat (4) @(posedge clk);
        rd(8'h04, v);
        chk(n, e, v & m);
    endtask

    // ==========================================
    // Scenarios
    task automatic s_cmp();
        core(4'h5, 4'hc, 3'h0, 2'h0);
        xr("cmp_conv", 4'h7, 2'h0, 6'h0, 32'hc5, 32'hff);
        chk("cmp_nop", 32'h0, {24'h0, cmp});
        q1 <= 4'h8;
        xr("cmp_set", 4'h7, 2'h0, 6'h0, 32'hc5, 32'hff);
        chk("cmp_val", 32'hc5, {24'h0, cmp});
        core(4'h0, 4'h0, 3'h0, 2'h0);
        xr("adc_cmp", 4'h1, 2'h0, 6'h0, 32'hc5, 32'hff);
        q1 <= 4'h7;
    endtask
    task automatic s_pair();
        wr(8'h08, 32'h5a);
        xr("timer4", 4'h0, 2'h0, 6'h0, {24'h0, t4[7:4], t4[3:0]}, 32'hff);
        xr("adc_conv", 4'h1, 2'h0, 6'h0, {24'h0, adr[9:6], adr[5:2]}, 32'hff);
        xr("ereg", 4'h2, 2'h0, 6'h0, 32'h5a, 32'hff);
        xr("presc", 4'h4, 2'h0, 6'h0, {24'h0, timer_prescaler}, 32'hff);
        xr("shift", 4'h5, 2'h0, 6'h0, {24'h0, ssr}, 32'hff);
    endtask
    task automatic s_nib();
        core(4'hf, 4'h0, 3'h5, 2'h0);
        xr("dreg", 4'h6, 2'h0, 6'h0, 32'h5, 32'hf);
        xr("int1", 4'h8, 2'h0, 6'h0, {28'h0, i1}, 32'hf);
        xr("int2", 4'h9, 2'h0, 6'h0, {28'h0, i2}, 32'hf);
        xr("sctrl", 4'ha, 2'h0, 6'h0, {28'h0, sc}, 32'hf);
        xr("wake0", 4'hb, 2'h0, 6'h0, {28'h0, k0}, 32'hf);
        xr("wake1", 4'hc, 2'h0, 6'h0, {28'h0, k1}, 32'hf);
        xr("wake2", 4'hd, 2'h0, 6'h0, {28'h0, k2}, 32'hf);
        xr("adclo", 4'he, 2'h0, 6'h0, {28'h0, adr[1:0], 2'b00}, 32'hf);
    endtask
    task automatic s_mem();
        logic [9:0] w;
        logic [31:0] u;
        wr(8'h14, 32'h1a7);
        core(4'h0, 4'h0, 3'h0, 2'h1);
        xr("ramx", 4'hf, 2'h3, 6'h0, 32'h2001, 32'h300f);
        chk("ram_addr", 32'h1a7, {23'h0, ram_a});
        core(4'h3, 4'h0, 3'h5, 2'h0);
        w = {3'h5, 3'h5, 4'h3} ^ 10'h1c5;
        xr("lookup", 4'h3, 2'h0, 6'h2d, {13'h0, 3'h7, 6'h0, w}, 32'h707ff);
        chk("rom_addr", {19'h0, 6'h2d, 3'h5, 4'h3}, {19'h0, rom_a});
        rd(8'h1c, u);
        chk("unmapped", 32'h2, {30'h0, lresp});
        wr(8'h1c, 32'h0);
        chk("wr_unmapped", 32'h2, {30'h0, lresp});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        s_cmp();
        s_pair();
        s_nib();
        s_mem();
        test_done();
    end
endmodule
